// ==== msel_params.svh ====
`ifndef MSEL_PARAMS_SVH
`define MSEL_PARAMS_SVH

// Parameter list layout
`define HDR_LEN 8'h04
`define PG_EAA_CODE 6'h1d
`define PG_EAA_LEN 8'h12
`define PG_LCD_CODE 6'h22
`define PG_LCD_LEN 8'h52
`define PG_CFG_CODE 6'h3d
`define PG_CFG_LEN 8'h28
`define PG_EXT_CODE 6'h3e
`define EAA_BODY 18

// Element address defaults
`define DEF_HANDLER_ADDR 16'hf618
`define DEF_STORAGE_ADDR 16'h0000
`define DEF_IE_ADDR 16'hfa00
`define DEF_DRIVE_ADDR 16'hfde8
`define TRANSPORT_COUNT 16'h0001

// Completion answers
`define SK_NONE 4'h0
`define SK_ILLEGAL 4'h5
`define SK_UNIT_ATTN 4'h6
`define ASC_INVALID_PARAM 16'h2600
`define ASC_PARAMS_CHANGED 16'h2a01
`define INITIATORS 8

// Target register offsets
`define T_EVT 8'h00
`define T_MASK 8'h04
`define T_ADDR_A 8'h08
`define T_ADDR_B 8'h0c
`define T_SENSE 8'h10
// Target event bits
`define EV_CHANGED 0
`define EV_REJECTED 1
`define EV_UA 2

// Initiator register offsets
`define I_CTRL 8'h00
`define I_BUF 8'h04
`define I_STAT 8'h08
`define I_EVT 8'h0c
`define I_MASK 8'h10

`endif

// ==== msel_pkg.sv ====
package msel_pkg;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_HDR = 3'b001,
		T_CODE = 3'b011,
		T_LEN = 3'b010,
		T_BODY = 3'b110,
		T_DONE = 3'b111
	} tgt_state_e;
	typedef enum logic [1:0] {
		I_IDLE = 2'b00,
		I_CMD = 2'b01,
		I_SEND = 2'b11,
		I_WAIT = 2'b10
	} ini_state_e;
endpackage

// ==== mode_select_link.sv ====
interface mode_select_link;
	logic bus_reset;
	logic cmd_valid;
	logic [2:0] cmd_initiator;
	logic cmd_save_pages;
	logic cmd_page_format;
	logic [7:0] cmd_length;
	logic data_valid;
	logic [7:0] data_byte;
	logic done_valid;
	logic done_check;
	logic [3:0] done_sense_key;
	logic [15:0] done_asc;
	modport target(input bus_reset, cmd_valid, cmd_initiator, cmd_save_pages, cmd_page_format, cmd_length,
		data_valid, data_byte, output done_valid, done_check, done_sense_key, done_asc);
	modport initiator(output bus_reset, cmd_valid, cmd_initiator, cmd_save_pages, cmd_page_format, cmd_length,
		data_valid, data_byte, input done_valid, done_check, done_sense_key, done_asc);
endinterface

// ==== mode_select_target.sv ====
`include "msel_params.svh"
module mode_select_target import msel_pkg::*; (
	input wire logic clk_in,
	input wire logic reset_n_in,
	mode_select_link.target link,
	input wire logic [15:0] cfg_storage_count_in,
	input wire logic [15:0] cfg_ie_count_in,
	input wire logic [15:0] cfg_drive_count_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic irq_out,
	output logic nv_write_out
);
	tgt_state_e state_q;
	logic [7:0] remain_q;
	logic [7:0] idx_q;
	logic [7:0] pg_len_q;
	logic [1:0] pg_sel_q;
	logic [3:0] seen_q;
	logic err_q;
	logic ua_hit_q;
	logic sp_q;
	logic [2:0] init_q;
	logic [7:0] body_q [0:`EAA_BODY-1];
	logic ua_pend_q [0:`INITIATORS-1];
	logic [15:0] cur_hand_q, cur_stor_q, cur_ie_q, cur_drv_q;
	logic [15:0] sav_hand_q, sav_stor_q, sav_ie_q, sav_drv_q;
	logic [2:0] evt_q;
	logic [2:0] mask_q;
	logic [3:0] last_sk_q;
	logic [15:0] last_asc_q;
	logic last_byte, at_bound, eaa_bad, accept;
	logic [1:0] code_sel;
	logic code_ok;

	function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
		be16 = {hi, lo};
	endfunction

	// Page code decode
	always_comb begin
		code_ok = 1'b1;
		code_sel = 2'd0;
		case (link.data_byte[5:0])
			`PG_EAA_CODE: code_sel = 2'd0;
			`PG_LCD_CODE: code_sel = 2'd1;
			`PG_CFG_CODE: code_sel = 2'd2;
			`PG_EXT_CODE: code_sel = 2'd3;
			default: code_ok = 1'b0;
		endcase
	end

	// Stream position checks
	assign last_byte = link.data_valid && (remain_q == 8'd1);
	always_comb begin
		case (state_q)
			T_HDR: at_bound = (idx_q == `HDR_LEN - 8'd1);
			T_LEN: at_bound = (link.data_byte == 8'h00);
			T_BODY: at_bound = (idx_q == pg_len_q - 8'd1);
			default: at_bound = 1'b0;
		endcase
	end

	// Element page field checks, body index is page byte minus two
	assign eaa_bad = seen_q[0] && (
		(be16(body_q[2], body_q[3]) != `TRANSPORT_COUNT) ||
		(be16(body_q[6], body_q[7]) != cfg_storage_count_in) ||
		(be16(body_q[10], body_q[11]) != cfg_ie_count_in) ||
		(be16(body_q[14], body_q[15]) != cfg_drive_count_in) ||
		(be16(body_q[16], body_q[17]) != 16'h0000));
	assign accept = (state_q == T_DONE) && !err_q && !ua_hit_q && !eaa_bad;

	// Command parser; bus reset aborts the command in flight
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || link.bus_reset) begin
			state_q <= T_IDLE;
			remain_q <= 8'h00;
			idx_q <= 8'h00;
			pg_len_q <= 8'h00;
			pg_sel_q <= 2'd0;
			seen_q <= 4'h0;
			err_q <= 1'b0;
			ua_hit_q <= 1'b0;
			sp_q <= 1'b0;
			init_q <= 3'd0;
		end else begin
			if (link.data_valid && state_q != T_IDLE && state_q != T_DONE) begin
				remain_q <= remain_q - 8'd1;
				if (last_byte && !at_bound)
					err_q <= 1'b1;
			end
			case (state_q)
				T_IDLE: if (link.cmd_valid) begin
					remain_q <= link.cmd_length;
					idx_q <= 8'h00;
					seen_q <= 4'h0;
					err_q <= !link.cmd_page_format;
					ua_hit_q <= ua_pend_q[link.cmd_initiator];
					sp_q <= link.cmd_save_pages;
					init_q <= link.cmd_initiator;
					state_q <= (link.cmd_length == 8'h00) ? T_DONE : T_HDR;
				end
				T_HDR: if (link.data_valid) begin
					if (link.data_byte != 8'h00)
						err_q <= 1'b1;
					idx_q <= idx_q + 8'd1;
					state_q <= last_byte ? T_DONE : (at_bound ? T_CODE : T_HDR);
				end
				T_CODE: if (link.data_valid) begin
					if (!code_ok || link.data_byte[7:6] != 2'b00 || seen_q[code_sel])
						err_q <= 1'b1;
					seen_q[code_sel] <= code_ok;
					pg_sel_q <= code_sel;
					state_q <= last_byte ? T_DONE : T_LEN;
				end
				T_LEN: if (link.data_valid) begin
					case (pg_sel_q)
						2'd0: if (link.data_byte != `PG_EAA_LEN) err_q <= 1'b1;
						2'd1: if (link.data_byte != `PG_LCD_LEN) err_q <= 1'b1;
						2'd2: if (link.data_byte != `PG_CFG_LEN) err_q <= 1'b1;
						default: ;
					endcase
					pg_len_q <= link.data_byte;
					idx_q <= 8'h00;
					state_q <= last_byte ? T_DONE : (at_bound ? T_CODE : T_BODY);
				end
				T_BODY: if (link.data_valid) begin
					idx_q <= idx_q + 8'd1;
					state_q <= last_byte ? T_DONE : (at_bound ? T_CODE : T_BODY);
				end
				T_DONE: state_q <= T_IDLE;
				default: state_q <= T_IDLE;
			endcase
		end
	end

	// Element page body capture, one slot per byte
	genvar g;
	generate
		for (g = 0; g < `EAA_BODY; g++) begin : g_body
			always_ff @(posedge clk_in) begin
				if (!reset_n_in)
					body_q[g] <= 8'h00;
				else if (state_q == T_BODY && link.data_valid && pg_sel_q == 2'd0 && idx_q == 8'(g))
					body_q[g] <= link.data_byte;
			end
		end
	endgenerate

	// Pending unit attention per initiator; a set beats the clear
	// A list without pages changes nothing, so it posts no attention
	generate
		for (g = 0; g < `INITIATORS; g++) begin : g_ua
			always_ff @(posedge clk_in) begin
				if (!reset_n_in)
					ua_pend_q[g] <= 1'b0;
				else if (accept && seen_q != 4'h0 && init_q != 3'(g))
					ua_pend_q[g] <= 1'b1;
				else if (state_q == T_DONE && ua_hit_q && init_q == 3'(g))
					ua_pend_q[g] <= 1'b0;
			end
		end
	endgenerate

	// Saved copy, only a power-up reset restores defaults
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sav_hand_q <= `DEF_HANDLER_ADDR;
			sav_stor_q <= `DEF_STORAGE_ADDR;
			sav_ie_q <= `DEF_IE_ADDR;
			sav_drv_q <= `DEF_DRIVE_ADDR;
		end else if (accept && seen_q[0] && sp_q) begin
			sav_hand_q <= be16(body_q[0], body_q[1]);
			sav_stor_q <= be16(body_q[4], body_q[5]);
			sav_ie_q <= be16(body_q[8], body_q[9]);
			sav_drv_q <= be16(body_q[12], body_q[13]);
		end
	end

	// Current set: reloaded from saved on bus reset, updated on accept only
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			cur_hand_q <= `DEF_HANDLER_ADDR;
			cur_stor_q <= `DEF_STORAGE_ADDR;
			cur_ie_q <= `DEF_IE_ADDR;
			cur_drv_q <= `DEF_DRIVE_ADDR;
		end else if (link.bus_reset) begin
			cur_hand_q <= sav_hand_q;
			cur_stor_q <= sav_stor_q;
			cur_ie_q <= sav_ie_q;
			cur_drv_q <= sav_drv_q;
		end else if (accept && seen_q[0]) begin
			cur_hand_q <= be16(body_q[0], body_q[1]);
			cur_stor_q <= be16(body_q[4], body_q[5]);
			cur_ie_q <= be16(body_q[8], body_q[9]);
			cur_drv_q <= be16(body_q[12], body_q[13]);
		end
	end

	// Completion answer, two cycles after the last byte
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			link.done_valid <= 1'b0;
			link.done_check <= 1'b0;
			link.done_sense_key <= `SK_NONE;
			link.done_asc <= 16'h0000;
			nv_write_out <= 1'b0;
		end else begin
			link.done_valid <= (state_q == T_DONE) && !link.bus_reset;
			nv_write_out <= 1'b0;
			if (state_q == T_DONE) begin
				link.done_check <= !accept;
				if (ua_hit_q) begin
					link.done_sense_key <= `SK_UNIT_ATTN;
					link.done_asc <= `ASC_PARAMS_CHANGED;
				end else if (!accept) begin
					link.done_sense_key <= `SK_ILLEGAL;
					link.done_asc <= `ASC_INVALID_PARAM;
				end else begin
					link.done_sense_key <= `SK_NONE;
					link.done_asc <= 16'h0000;
				end
				// Config and external pages reach storage even with save-pages clear
				nv_write_out <= accept && ((sp_q && seen_q != 4'h0) || seen_q[2] || seen_q[3]);
			end
		end
	end

	// Sticky events, set wins over the read clear
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			evt_q <= 3'b000;
			mask_q <= 3'b000;
			last_sk_q <= `SK_NONE;
			last_asc_q <= 16'h0000;
		end else begin
			evt_q <= ((rd_in && addr_in == `T_EVT) ? 3'b000 : evt_q) | {
				state_q == T_DONE && ua_hit_q,
				state_q == T_DONE && !accept && !ua_hit_q,
				accept && seen_q != 4'h0};
			if (wr_in && addr_in == `T_MASK)
				mask_q <= wdata_in[2:0];
			// Taken once the answer stands, not while it is being built
			if (link.done_valid) begin
				last_sk_q <= link.done_sense_key;
				last_asc_q <= link.done_asc;
			end
		end
	end

	// Register reads; unmapped offsets read zero
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h0000_0000;
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(evt_q & mask_q);
			rdata_out <= 32'h0000_0000;
			if (rd_in) begin
				case (addr_in)
					`T_EVT: rdata_out <= {29'h0, evt_q};
					`T_MASK: rdata_out <= {29'h0, mask_q};
					`T_ADDR_A: rdata_out <= {cur_stor_q, cur_hand_q};
					`T_ADDR_B: rdata_out <= {cur_drv_q, cur_ie_q};
					`T_SENSE: rdata_out <= {12'h0, last_sk_q, last_asc_q};
					default: rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ==== mode_select_initiator.sv ====
`include "msel_params.svh"
module mode_select_initiator import msel_pkg::*; (
	input wire logic clk_in,
	input wire logic reset_n_in,
	mode_select_link.initiator link,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic irq_out
);
	ini_state_e state_q;
	logic [7:0] buf_q [0:255];
	logic [7:0] idx_q;
	logic [7:0] len_q;
	logic check_q;
	logic [3:0] sk_q;
	logic [15:0] asc_q;
	logic evt_q, mask_q;
	logic go;

	assign go = wr_in && addr_in == `I_CTRL && wdata_in[0] && state_q == I_IDLE;

	// Parameter list buffer; software builds header and pages in any order
	always_ff @(posedge clk_in) begin
		if (wr_in && addr_in == `I_BUF)
			buf_q[wdata_in[7:0]] <= wdata_in[15:8];
	end

	// Command sequencer
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= I_IDLE;
			idx_q <= 8'h00;
			len_q <= 8'h00;
			link.bus_reset <= 1'b0;
			link.cmd_valid <= 1'b0;
			link.cmd_initiator <= 3'd0;
			link.cmd_save_pages <= 1'b0;
			link.cmd_page_format <= 1'b0;
			link.cmd_length <= 8'h00;
			link.data_valid <= 1'b0;
			link.data_byte <= 8'h00;
		end else begin
			link.bus_reset <= wr_in && addr_in == `I_CTRL && wdata_in[1];
			link.cmd_valid <= 1'b0;
			link.data_valid <= 1'b0;
			case (state_q)
				I_IDLE: if (go && !wdata_in[1]) begin
					link.cmd_valid <= 1'b1;
					link.cmd_save_pages <= wdata_in[2];
					link.cmd_page_format <= wdata_in[3];
					link.cmd_initiator <= wdata_in[6:4];
					link.cmd_length <= wdata_in[15:8];
					len_q <= wdata_in[15:8];
					idx_q <= 8'h00;
					state_q <= I_CMD;
				end
				I_CMD: state_q <= (len_q == 8'h00) ? I_WAIT : I_SEND;
				I_SEND: begin
					link.data_valid <= 1'b1;
					link.data_byte <= buf_q[idx_q];
					idx_q <= idx_q + 8'd1;
					if (idx_q == len_q - 8'd1)
						state_q <= I_WAIT;
				end
				I_WAIT: if (link.done_valid)
					state_q <= I_IDLE;
				default: state_q <= I_IDLE;
			endcase
			// A bus reset abandons any answer still owed
			if (link.bus_reset)
				state_q <= I_IDLE;
		end
	end

	// Completion capture and interrupt, set wins over read clear
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			check_q <= 1'b0;
			sk_q <= `SK_NONE;
			asc_q <= 16'h0000;
			evt_q <= 1'b0;
			mask_q <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			if (link.done_valid) begin
				check_q <= link.done_check;
				sk_q <= link.done_sense_key;
				asc_q <= link.done_asc;
			end
			evt_q <= link.done_valid || (evt_q && !(rd_in && addr_in == `I_EVT));
			if (wr_in && addr_in == `I_MASK)
				mask_q <= wdata_in[0];
			irq_out <= evt_q && mask_q;
		end
	end

	// Register reads
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h0000_0000;
		end else begin
			rdata_out <= 32'h0000_0000;
			if (rd_in) begin
				case (addr_in)
					`I_STAT: rdata_out <= {asc_q, 8'h00, sk_q, 2'b00, check_q, state_q != I_IDLE};
					`I_EVT: rdata_out <= {31'h0, evt_q};
					`I_MASK: rdata_out <= {31'h0, mask_q};
					default: rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ==== mode_select_properties.sv ====
module mode_select_checker (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic bus_reset,
	input wire logic cmd_valid,
	input wire logic cmd_page_format,
	input wire logic [7:0] cmd_length,
	input wire logic data_valid,
	input wire logic [7:0] data_byte,
	input wire logic done_valid,
	input wire logic done_check,
	input wire logic [3:0] done_sense_key,
	input wire logic [15:0] done_asc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt_q;
	logic [7:0] len_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// Bytes seen since the command, restarted by any abort
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || cmd_valid || bus_reset) cnt_q <= 9'h000;
		else if (data_valid) cnt_q <= cnt_q + 9'h001;
	end
	// Length of the command in flight
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) len_q <= 8'h00;
		else if (cmd_valid) len_q <= cmd_length;
	end
	sequence cmd_s;
		cmd_valid && !bus_reset;
	endsequence
	sequence fail_s;
		done_valid && done_check;
	endsequence
	// Windows of 300 cover the longest list of 255 bytes
	done_pulse_a: assert property (done_valid |=> !done_valid) else $error("done held too long");
	data_start_a: assert property (cmd_s ##0 (cmd_length != 8'h00) |-> ##2 data_valid)
		else $error("data did not start two cycles after command");
	byte_count_a: assert property (done_valid |-> cnt_q == {1'b0, len_q})
		else $error("done before all bytes arrived");
	empty_quiet_a: assert property (cmd_s ##0 (cmd_length == 8'h00) |=> !data_valid [*3])
		else $error("bytes sent for empty list");
	empty_done_a: assert property (cmd_s ##0 (cmd_length == 8'h00) |-> ##[1:3] done_valid)
		else $error("empty list not answered");
	header_zero_a: assert property (data_valid && cnt_q < 9'h004 && data_byte != 8'h00 |-> ##[1:300] fail_s)
		else $error("nonzero header accepted");
	pf_refuse_a: assert property (cmd_s ##0 !cmd_page_format |-> ##[1:300] fail_s)
		else $error("page format zero accepted");
	ua_code_a: assert property (done_valid && done_sense_key == 4'h6 |-> done_check && done_asc == 16'h2a01)
		else $error("unit attention answer wrong");
	bad_code_a: assert property (done_valid && done_sense_key == 4'h5 |-> done_check && done_asc == 16'h2600)
		else $error("illegal request answer wrong");
	// An answer already standing when the abort lands belongs to a finished command
	abort_quiet_a: assert property (bus_reset && !done_valid |=> !done_valid [*2])
		else $error("done after abort");
endmodule

// ==== testbench.sv ====
`include "msel_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_n_in, t_wr, t_rd, i_wr, i_rd, t_irq, i_irq, nv, pend, ptgt;
	logic [7:0] addr;
	logic [31:0] wdata, t_rdata, i_rdata, nv_cnt, sa, sb;
	logic [15:0] sc, iec, drc, h, st, ie, dr;
	logic [7:0] pg [48];
	logic [31:0] exp_q [$];
	int mismatches, checks;
	mode_select_link link();
	mode_select_target u_mode_select_target (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
		.cfg_storage_count_in(sc), .cfg_ie_count_in(iec), .cfg_drive_count_in(drc), .addr_in(addr),
		.wdata_in(wdata), .wr_in(t_wr), .rd_in(t_rd), .rdata_out(t_rdata), .irq_out(t_irq), .nv_write_out(nv));
	mode_select_initiator u_mode_select_initiator (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
		.addr_in(addr), .wdata_in(wdata), .wr_in(i_wr), .rd_in(i_rd), .rdata_out(i_rdata), .irq_out(i_irq));
	mode_select_checker u_mode_select_checker (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_reset(link.bus_reset),
		.cmd_valid(link.cmd_valid), .cmd_page_format(link.cmd_page_format), .cmd_length(link.cmd_length),
		.data_valid(link.data_valid), .data_byte(link.data_byte), .done_valid(link.done_valid),
		.done_check(link.done_check), .done_sense_key(link.done_sense_key), .done_asc(link.done_asc));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task complete_run();
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Read data stand only in the cycle after the strobe, so look then
	always @(posedge clk_in) begin
		if (pend) check(ptgt ? t_rdata : i_rdata, exp_q.pop_front());
		pend <= t_rd | i_rd;
		ptgt <= t_rd;
	end
	always @(posedge clk_in) if (nv === 1'b1) nv_cnt++;
	task acc(input logic tgt, input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		if (tgt) {t_wr, t_rd} <= {w, !w};
		else {i_wr, i_rd} <= {w, !w};
		@(posedge clk_in);
		{t_wr, t_rd, i_wr, i_rd} <= 4'h0;
	endtask
	task rd(input logic tgt, input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(tgt, 1'b0, a, 32'h0);
	endtask
	// Load the list, start it, wait a bounded time for the answer
	task cmd(input logic [2:0] id, input logic sp, input logic pf, input logic [7:0] len);
		int i;
		for (i = 0; i < len; i++) acc(1'b0, 1'b1, `I_BUF, {16'h0, pg[i], 8'(i)});
		acc(1'b0, 1'b1, `I_CTRL, {16'h0, len, 1'b0, id, pf, sp, 2'b01});
		i = 0;
		while (link.done_valid !== 1'b1 && i < 400) begin
			@(posedge clk_in);
			i++;
		end
		repeat (3) @(posedge clk_in);
	endtask
	task res(input logic [31:0] s, input logic [31:0] a, input logic [31:0] b);
		rd(1'b1, `T_SENSE, s);
		rd(1'b1, `T_ADDR_A, a);
		rd(1'b1, `T_ADDR_B, b);
	endtask
	task mk();
		{pg[0], pg[1], pg[2], pg[3], pg[4], pg[5]} = 48'h1d12;
		{pg[6], pg[7], pg[8], pg[9], pg[10], pg[11], pg[12], pg[13]} = {h, 16'h0001, st, sc};
		{pg[14], pg[15], pg[16], pg[17], pg[18], pg[19]} = {ie, iec, dr};
		{pg[20], pg[21], pg[22], pg[23]} = {drc, 16'h0};
	endtask
	task bus_reset();
		acc(1'b0, 1'b1, `I_CTRL, 32'h2);
		repeat (4) @(posedge clk_in);
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		complete_run();
	end
	initial begin
		logic pf;
		logic [7:0] len;
		{reset_n_in, t_wr, t_rd, i_wr, i_rd, pend, ptgt, addr, wdata} = '0;
		nv_cnt = 32'h0;
		void'($urandom(35));
		sc = 16'($urandom_range(300, 1));
		iec = 16'($urandom_range(1, 0));
		drc = 16'($urandom_range(8, 1));
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		sa = {`DEF_STORAGE_ADDR, `DEF_HANDLER_ADDR};
		sb = {`DEF_DRIVE_ADDR, `DEF_IE_ADDR};
		rd(1'b1, `T_ADDR_A, sa);
		rd(1'b1, `T_ADDR_B, sb);
		acc(1'b1, 1'b1, `T_MASK, 32'h1);
		acc(1'b0, 1'b1, `I_MASK, 32'h1);
		// Current-only update from one initiator
		{h, st, ie, dr} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
		mk();
		cmd(3'h1, 1'b0, 1'b1, 8'd24);
		check({t_irq, i_irq}, 2'b11);
		res(32'h0, {st, h}, {dr, ie});
		rd(1'b1, `T_EVT, 32'h1);
		rd(1'b0, `I_EVT, 32'h1);
		rd(1'b0, `I_STAT, 32'h0);
		repeat (2) @(posedge clk_in);
		check({t_irq, i_irq}, 2'b00);
		check(nv_cnt, 32'h0);
		// Another initiator is told first, then served
		cmd(3'h2, 1'b0, 1'b1, 8'd0);
		res(32'h00062a01, {st, h}, {dr, ie});
		rd(1'b0, `I_STAT, 32'h2a010062);
		cmd(3'h2, 1'b0, 1'b1, 8'd0);
		res(32'h0, {st, h}, {dr, ie});
		// External data page writes storage without save-pages
		{pg[4], pg[5]} = 16'h3e00;
		cmd(3'h1, 1'b0, 1'b1, 8'd6);
		check(nv_cnt, 32'h1);
		bus_reset();
		res(32'h0, sa, sb);
		// Saved update survives a bus reset
		{h, st, ie, dr} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
		mk();
		cmd(3'h1, 1'b1, 1'b1, 8'd24);
		check(nv_cnt, 32'h2);
		bus_reset();
		res(32'h0, {st, h}, {dr, ie});
		// One bad field each; nothing may change
		for (int k = 0; k < 9; k++) begin
			// Offered handler and storage addresses differ from the current ones, so a partial update would show
			{h, st} = ~{h, st};
			mk();
			{h, st} = ~{h, st};
			pf = 1'b1;
			len = 8'd24;
			case (k)
				0: pg[1] = 8'h01;
				1: pg[4] = 8'h1e;
				2: pg[5] = 8'h13;
				3: pg[9] = 8'h02;
				4: pg[13] = sc[7:0] + 8'h01;
				5: pg[23] = 8'h01;
				6: pf = 1'b0;
				7: begin
					for (int j = 4; j < 24; j++) pg[j + 20] = pg[j];
					len = 8'd44;
				end
				default: len = 8'd2;
			endcase
			cmd(3'h1, 1'b1, pf, len);
			res(32'h00052600, {st, h}, {dr, ie});
		end
		check(nv_cnt, 32'h2);
		// Changed, rejected and attention events have all been seen since the last clear
		rd(1'b1, `T_EVT, 32'h7);
		complete_run();
	end
endmodule
